// ### src/sram_ctrl_pkg.sv
package sram_ctrl_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int WORDS  = 32768;

    // timing figures in ns, slower speed grade
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_RC_NS       = 35;  // read cycle, address access
    localparam int T_WP_NS       = 20;  // write pulse width
    localparam int T_AS_NS       = 0;   // address setup before strobe low
    localparam int T_DH_NS       = 0;   // data hold after strobe high
    localparam int T_OHZ_NS      = 15;  // output disable to high z

    // least times round up; setup and hold never below one cycle
    localparam int RD_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AS_CYC  = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                             (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DH_CYC  = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                             (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OHZ_CYC = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_TURN,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD
    } state_e;

endpackage

// ### src/sram_host_ctrl.sv
`timescale 1ns/1ps

module sram_host_ctrl #(
    parameter int AW = sram_ctrl_pkg::ADDR_W,
    parameter int DW = sram_ctrl_pkg::DATA_W
) (
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    // user side
    input  wire logic          reqValid,
    output logic               reqReady,
    input  wire logic          reqWrite,
    input  wire logic [AW-1:0] reqAddr,
    input  wire logic [DW-1:0] reqData,
    output logic               rspValid,
    output logic [DW-1:0]      rspData,
    // memory pins
    output logic [AW-1:0]      memAddr,
    output logic               selectLowActive_n,
    output logic               selectHighActive,
    output logic               outEnable_n,
    output logic               writeStrobe_n,
    input  wire logic [DW-1:0] dqIn,
    output logic [DW-1:0]      dqOut,
    output logic               dqOe_n
);

    // counter width, kept short so the casts below stay readable
    localparam int CW = sram_ctrl_pkg::CNT_W;

    // sequencer state and the phase counter
    sram_ctrl_pkg::state_e                     state_reg, state_next;
    logic [sram_ctrl_pkg::CNT_W-1:0]           cnt_reg, cnt_next;

    // copy of the request, held for the whole access so no pin moves mid-cycle
    logic [AW-1:0]                             addr_reg, addr_next;
    logic [DW-1:0]                             wdata_reg, wdata_next;
    logic [DW-1:0]                             rdata_reg, rdata_next;
    logic                                      rspValid_reg, rspValid_next;

    // pin levels, active high inside and inverted only at the pins
    logic                                      sel_reg, sel_next;
    logic                                      oe_reg, oe_next;
    logic                                      we_reg, we_next;
    logic                                      drive_reg, drive_next;

    // phase lengths as counter loads; every least time is rounded up,
    // so a phase may run long, by a whole cycle for the 0 ns setup and hold, but never short
    localparam logic [CW-1:0] RD_N  = CW'(sram_ctrl_pkg::RD_CYC);
    localparam logic [CW-1:0] WP_N  = CW'(sram_ctrl_pkg::WP_CYC);
    localparam logic [CW-1:0] AS_N  = CW'(sram_ctrl_pkg::AS_CYC);
    localparam logic [CW-1:0] DH_N  = CW'(sram_ctrl_pkg::DH_CYC);
    localparam logic [CW-1:0] OHZ_N = CW'(sram_ctrl_pkg::OHZ_CYC);

    // accept new work only when idle and the bus has turned round
    // a request that arrives mid-access simply waits; nothing is dropped
    assign reqReady = (state_reg == sram_ctrl_pkg::ST_IDLE);

    // sequencer: every access selects, waits, then deselects before the next
    // dropping the selects between words costs a cycle each, but every access
    // then starts with the strobe high and a settled address
    always_comb begin
        // hold everything unless a state says otherwise; the answer is a pulse
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        addr_next     = addr_reg;
        wdata_next    = wdata_reg;
        rdata_next    = rdata_reg;
        rspValid_next = 1'b0;
        sel_next      = sel_reg;
        oe_next       = oe_reg;
        we_next       = we_reg;
        drive_next    = drive_reg;
        case (state_reg)
            // idle: capture the whole request so the pins stay put for the access
            sram_ctrl_pkg::ST_IDLE: begin
                if (reqValid) begin
                    addr_next  = reqAddr;              // strobe is high here
                    wdata_next = reqData;              // ninth bit passed as is
                    sel_next   = 1'b1;                 // both selects together
                    // direction is picked once, at the take
                    if (reqWrite) begin
                        oe_next    = 1'b0;             // memory not driving
                        drive_next = 1'b1;
                        cnt_next   = AS_N;
                        state_next = sram_ctrl_pkg::ST_WR_SETUP;
                    end else begin
                        oe_next    = 1'b1;             // strobe stays high
                        drive_next = 1'b0;             // host floats dq
                        cnt_next   = RD_N;
                        state_next = sram_ctrl_pkg::ST_RD_WAIT;
                    end
                end
            end

            // read: address, selects and enable stand for the full access time
            sram_ctrl_pkg::ST_RD_WAIT: begin
                if (cnt_reg == 4'h1) begin
                    rdata_next    = dqIn;              // sampled after full access time
                    rspValid_next = 1'b1;
                    sel_next      = 1'b0;              // deselect floats memory
                    oe_next       = 1'b0;
                    cnt_next      = OHZ_N;
                    state_next    = sram_ctrl_pkg::ST_RD_TURN;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end

            sram_ctrl_pkg::ST_RD_TURN: begin
                // wait out the memory's float time before anyone drives dq
                if (cnt_reg == 4'h1) begin
                    state_next = sram_ctrl_pkg::ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end

            // write setup: selects, address and data settle before the strobe falls
            sram_ctrl_pkg::ST_WR_SETUP: begin
                if (cnt_reg == 4'h1) begin
                    we_next    = 1'b1;                 // strobe falls after selects
                    cnt_next   = WP_N;
                    state_next = sram_ctrl_pkg::ST_WR_PULSE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end

            // write pulse: strobe low for at least the least pulse width
            sram_ctrl_pkg::ST_WR_PULSE: begin
                if (cnt_reg == 4'h1) begin
                    we_next    = 1'b0;                 // strobe rise ends the write
                    cnt_next   = DH_N;
                    state_next = sram_ctrl_pkg::ST_WR_HOLD;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end

            sram_ctrl_pkg::ST_WR_HOLD: begin
                // data and address held past the terminating edge
                if (cnt_reg == 4'h1) begin
                    sel_next      = 1'b0;
                    drive_next    = 1'b0;
                    rspValid_next = 1'b1;
                    state_next    = sram_ctrl_pkg::ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end

            // unused codes fall back to idle with every pin released
            default: begin
                state_next = sram_ctrl_pkg::ST_IDLE;
                sel_next   = 1'b0;
                oe_next    = 1'b0;
                we_next    = 1'b0;
                drive_next = 1'b0;
            end
        endcase
    end

    // registers only; pins come straight from flops, no glitches
    // reset parks the bus: selects off, strobe and enable high, dq released
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg    <= sram_ctrl_pkg::ST_IDLE;
            cnt_reg      <= 4'h0;
            addr_reg     <= '0;
            wdata_reg    <= '0;
            rdata_reg    <= '0;
            rspValid_reg <= 1'b0;
            sel_reg      <= 1'b0;
            oe_reg       <= 1'b0;
            we_reg       <= 1'b0;
            drive_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            addr_reg     <= addr_next;
            wdata_reg    <= wdata_next;
            rdata_reg    <= rdata_next;
            rspValid_reg <= rspValid_next;
            sel_reg      <= sel_next;
            oe_reg       <= oe_next;
            we_reg       <= we_next;
            drive_reg    <= drive_next;
        end
    end

    // pin mapping, 15 address and 9 data bits
    assign memAddr           = addr_reg;
    assign selectLowActive_n = ~sel_reg;
    assign selectHighActive  = sel_reg;
    assign outEnable_n       = ~oe_reg;
    assign writeStrobe_n     = ~we_reg;                // low writes, high reads
    assign dqOut             = wdata_reg;
    assign dqOe_n            = ~drive_reg;             // low while host drives dq

    // answer to the user side, also straight from flops
    assign rspValid          = rspValid_reg;
    assign rspData           = rdata_reg;

endmodule

// ### sim/sram_host_ctrl_monitor.sv
`timescale 1ns/1ps
// pin-level protocol checks on the host controller
module sram_host_ctrl_monitor (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        rspValid,
    input wire logic [14:0] memAddr,
    input wire logic        selectLowActive_n,
    input wire logic        selectHighActive,
    input wire logic        outEnable_n,
    input wire logic        writeStrobe_n,
    input wire logic [8:0]  dqOut,
    input wire logic        dqOe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic sel;
    // both selects must agree before any access counts
    assign sel = !selectLowActive_n && selectHighActive;
    a_strobe_in_select: assert property (!writeStrobe_n |-> sel)
        else $error("write strobe low while deselected");
    a_addr_strobe_high: assert property ($changed(memAddr) |-> writeStrobe_n)
        else $error("address moved with strobe low");
    a_read_strobe_high: assert property (!outEnable_n |-> writeStrobe_n && sel)
        else $error("read without strobe high and select");
    a_no_bus_fight: assert property (!dqOe_n |-> outEnable_n)
        else $error("host drives data during read");
    a_pulse_width: assert property (
        $fell(writeStrobe_n) |-> !writeStrobe_n[*3] ##1 writeStrobe_n)
        else $error("write pulse not three cycles");
    a_data_hold: assert property (!writeStrobe_n |=> $stable(dqOut) && !dqOe_n)
        else $error("write data moved around strobe end");
    a_read_window: assert property ($fell(outEnable_n) |-> (!outEnable_n && sel)[*5])
        else $error("read access window too short");
    a_float_wait: assert property ($rose(outEnable_n) |-> dqOe_n[*2])
        else $error("host drove data before float time");
    a_answer_time: assert property (reqValid && reqReady |-> ##[6:7] rspValid)
        else $error("answer late");
    a_idle_after_rsp: assert property (rspValid |-> !sel)
        else $error("still selected at answer");
    cover property ($fell(writeStrobe_n));
    cover property ($rose(outEnable_n));
    cover property (rspValid ##1 reqValid && reqReady);
endmodule
bind sram_host_ctrl sram_host_ctrl_monitor u_sram_host_ctrl_monitor (.*);

// ### sim/sram_model.sv
`timescale 1ns/1ps
// behavioural memory; read data settles late so the host wait matters
module sram_model #(parameter int ACCESS_NS = 30) (
    input wire logic        sys_clk,
    input wire logic [14:0] memAddr,
    input wire logic        selectLowActive_n,
    input wire logic        selectHighActive,
    input wire logic        outEnable_n,
    input wire logic        writeStrobe_n,
    input wire logic [8:0]  dq,
    output logic            drive,
    output logic [8:0]      rdData
);
    logic [8:0] mem [sram_ctrl_pkg::WORDS];
    logic sel;
    assign sel = !selectLowActive_n && selectHighActive;
    // drive only in a read, so strobe-first cycles stay off
    assign drive = sel && writeStrobe_n && !outEnable_n;
    assign #(ACCESS_NS) rdData = mem[memAddr];
    // ninth bit stored plainly, no parity logic
    always @(negedge sys_clk) if (sel && !writeStrobe_n) mem[memAddr] <= dq;
endmodule

// ### sim/test_sram_host_ctrl.sv
`timescale 1ns/1ps
module test_sram_host_ctrl;
    logic sys_clk = 0, sys_rst = 1, reqValid = 0, reqWrite = 0, reqReady, rspValid;
    logic [14:0] reqAddr = 15'h0000, memAddr;
    logic [8:0]  reqData = 9'h000, rspData, dqIn, dqOut, rdData, lastDq = 9'h000, q;
    logic        selectLowActive_n, selectHighActive, outEnable_n, writeStrobe_n, dqOe_n, drive;
    int errorCnt = 0, numChecks = 0, cyc = 0;
    sram_host_ctrl u_sram_host_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .reqValid(reqValid),
        .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
        .rspValid(rspValid), .rspData(rspData), .memAddr(memAddr), .dqIn(dqIn),
        .selectLowActive_n(selectLowActive_n), .selectHighActive(selectHighActive),
        .outEnable_n(outEnable_n), .writeStrobe_n(writeStrobe_n), .dqOut(dqOut), .dqOe_n(dqOe_n));
    sram_model u_sram_model (.sys_clk(sys_clk), .memAddr(memAddr), .dq(dqIn), .drive(drive),
        .selectLowActive_n(selectLowActive_n), .selectHighActive(selectHighActive),
        .outEnable_n(outEnable_n), .writeStrobe_n(writeStrobe_n), .rdData(rdData));
    // a floating bus shows the inverse of its last level, never a lucky match
    assign dqIn = !dqOe_n ? dqOut : drive ? rdData : ~lastDq;
    always @(posedge sys_clk) lastDq <= dqIn;
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            errorCnt++;
            summarize();
        end
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one whole transfer, entered and left just after a rising edge
    task automatic access(input logic wr, input logic [14:0] a, input logic [8:0] d);
        int n;
        int expCyc;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqData <= d;
        n = 0;
        @(negedge sys_clk);
        while (reqReady !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        reqValid <= 1'b0;
        n = 0;
        @(negedge sys_clk);
        while (rspValid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk({8'h00, rspValid}, 9'h001);
        // answer comes after setup, pulse and hold, or after the full access
        expCyc = wr ? sram_ctrl_pkg::AS_CYC + sram_ctrl_pkg::WP_CYC + sram_ctrl_pkg::DH_CYC
                    : sram_ctrl_pkg::RD_CYC;
        chk(9'(n), 9'(expCyc));
        // a read keeps new work out until the memory has let go of dq
        chk({8'h00, reqReady}, {8'h00, wr});
        q = rspData;
        @(posedge sys_clk);
    endtask
    // pins looked at mid-cycle, away from the edge that launches them
    task automatic idle_pins();
        @(negedge sys_clk);
        chk({4'h0, selectLowActive_n, selectHighActive, outEnable_n, writeStrobe_n, dqOe_n},
            9'h017);
        chk({8'h00, drive}, 9'h000);
        @(posedge sys_clk);
    endtask
    // each address bit alone, ninth bit alternating
    task automatic addr_bits();
        for (int i = 0; i < 15; i++) access(1'b1, 15'h0001 << i, {i[0], 8'(i + 1)});
        for (int i = 0; i < 15; i++) begin
            access(1'b0, 15'h0001 << i, 9'h000);
            chk(q, {i[0], 8'(i + 1)});
        end
    endtask
    // back-to-back overwrite of the top word, then two reads
    task automatic overwrite();
        access(1'b1, 15'h7FFF, 9'h0AA);
        access(1'b1, 15'h7FFF, 9'h155);
        access(1'b0, 15'h7FFF, 9'h000);
        chk(q, 9'h155);
        access(1'b0, 15'h7FFF, 9'h000);
        chk(q, 9'h155);
        idle_pins();
    endtask
    task automatic summarize();
        if (errorCnt == 0 && numChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        idle_pins();
        addr_bits();
        overwrite();
        summarize();
    end
endmodule
